// File: common/sbfu_pkg.sv
// constants, operation kinds and opcode decoding for the shifter bit-field unit
`default_nettype none
package sbfu_pkg;
	localparam int FIX_W = 32;
	localparam int EXT_W = 8;
	localparam int WORD_W = 40;
	localparam int SH_W = 5;
	localparam int SHIMM_W = 8;
	localparam int IMM_W = 12;
	localparam int FLD_W = 6;
	localparam int OPC_W = 8;
	localparam int BIT_MAX = 31;
	localparam int SPAN_MAX = 32;
	localparam int BUS_W = 32;
	localparam int BE_W = 4;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_SRC = 5'h00;
	localparam logic [ADDR_W-1:0] REG_DST = 5'h04;
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h08;
	localparam logic [ADDR_W-1:0] REG_CMD = 5'h0c;
	localparam logic [ADDR_W-1:0] REG_STAT = 5'h10;
	localparam int CMD_OPC_LSB = 0;
	localparam int CMD_IMM_SEL = 8;
	localparam int CMD_IMM_LSB = 16;
	localparam int LEN_LSB = 0;
	localparam int POS_LSB = 6;
	localparam int ST_ZERO = 0;
	localparam int ST_OVF = 1;
	localparam int ST_SIGN = 2;
	localparam int ST_DONE = 3;
	localparam int ST_BAD = 4;
	localparam logic [OPC_W-1:0] OPC_ASH_OR = 8'h24;
	localparam logic [OPC_W-1:0] OPC_CIRC = 8'h08;
	localparam logic [OPC_W-1:0] OPC_BIT_ZERO = 8'hc4;
	localparam logic [OPC_W-1:0] OPC_BIT_ONE = 8'hc0;
	localparam logic [OPC_W-1:0] OPC_BIT_FLIP = 8'hc8;
	localparam logic [OPC_W-1:0] OPC_BIT_TEST = 8'hcc;
	localparam logic [OPC_W-1:0] OPC_DEPOSIT = 8'h44;
	localparam logic [OPC_W-1:0] OPC_DEPOSIT_OR = 8'h64;

	typedef enum logic [3:0] {
		OP_ASH_OR, OP_CIRC, OP_BIT_ZERO, OP_BIT_ONE, OP_BIT_FLIP,
		OP_BIT_TEST, OP_DEPOSIT, OP_DEPOSIT_OR, OP_NONE
	} sbfu_op_t;

	function automatic sbfu_op_t decode_op(input logic [OPC_W-1:0] opc);
		case (opc)
			OPC_ASH_OR: decode_op = OP_ASH_OR;
			OPC_CIRC: decode_op = OP_CIRC;
			OPC_BIT_ZERO: decode_op = OP_BIT_ZERO;
			OPC_BIT_ONE: decode_op = OP_BIT_ONE;
			OPC_BIT_FLIP: decode_op = OP_BIT_FLIP;
			OPC_BIT_TEST: decode_op = OP_BIT_TEST;
			OPC_DEPOSIT: decode_op = OP_DEPOSIT;
			OPC_DEPOSIT_OR: decode_op = OP_DEPOSIT_OR;
			default: decode_op = OP_NONE;
		endcase
	endfunction
endpackage
`default_nettype wire

// File: common/sbfu_if.sv
// operand and result bundle between the unit's control and its compute core
`timescale 1ns/1ps
`default_nettype none
interface sbfu_if;
	sbfu_pkg::sbfu_op_t kind;
	logic [sbfu_pkg::FIX_W-1:0] src;
	logic [sbfu_pkg::FIX_W-1:0] dst;
	logic signed [sbfu_pkg::FIX_W-1:0] amt;
	logic [sbfu_pkg::FLD_W-1:0] fld_len;
	logic [sbfu_pkg::FLD_W-1:0] fld_pos;
	logic [sbfu_pkg::FIX_W-1:0] res;
	logic zero;
	logic ovf;
	logic sign;
	logic we;
	modport core (input kind, src, dst, amt, fld_len, fld_pos,
		output res, zero, ovf, sign, we);
	modport ctl (output kind, src, dst, amt, fld_len, fld_pos,
		input res, zero, ovf, sign, we);
endinterface
`default_nettype wire

// File: hdl/sbfu_core.sv
// combinational compute core: shift, rotate, single-bit and deposit paths
`timescale 1ns/1ps
`default_nettype none
module sbfu_core (
	sbfu_if.core cif
);
	logic signed [sbfu_pkg::FIX_W-1:0] neg;
	logic [sbfu_pkg::FIX_W-1:0] ash;
	logic [2*sbfu_pkg::FIX_W-1:0] rot_w;
	logic [2*sbfu_pkg::FIX_W-1:0] dep_w;
	logic [sbfu_pkg::FIX_W-1:0] bmask;
	logic [sbfu_pkg::FIX_W-1:0] fmask;
	logic [sbfu_pkg::FLD_W:0] span;
	logic in_rng;
	logic big;

	assign neg = -cif.amt;
	assign in_rng = (cif.amt >= 0) && (cif.amt <= sbfu_pkg::BIT_MAX);
	assign big = cif.amt > sbfu_pkg::BIT_MAX;
	assign bmask = in_rng ? (32'h1 << cif.amt[sbfu_pkg::SH_W-1:0]) : '0;
	// modulo-32 amount: a negative count wraps to the equivalent left rotate
	assign rot_w = {cif.src, cif.src} << cif.amt[sbfu_pkg::SH_W-1:0];
	assign fmask = (cif.fld_len >= sbfu_pkg::SPAN_MAX) ? '1 :
		((32'h1 << cif.fld_len[sbfu_pkg::SH_W-1:0]) - 32'h1);
	assign dep_w = {{sbfu_pkg::FIX_W{1'b0}}, cif.src & fmask} << cif.fld_pos;
	assign span = {1'b0, cif.fld_len} + {1'b0, cif.fld_pos};
	assign cif.sign = 1'b0;

	always_comb begin
		if (cif.amt >= sbfu_pkg::FIX_W) begin
			ash = '0;
		end else if (cif.amt >= 0) begin
			ash = cif.src << cif.amt[sbfu_pkg::SH_W-1:0];
		end else if (cif.amt <= -sbfu_pkg::FIX_W) begin
			ash = {sbfu_pkg::FIX_W{cif.src[sbfu_pkg::FIX_W-1]}};
		end else begin
			ash = $signed(cif.src) >>> neg[sbfu_pkg::SH_W-1:0];
		end
	end

	always_comb begin
		cif.res = cif.dst;
		cif.zero = 1'b0;
		cif.ovf = 1'b0;
		cif.we = 1'b1;
		unique case (cif.kind)
			sbfu_pkg::OP_ASH_OR: begin
				cif.res = cif.dst | ash;
				cif.zero = ash == '0;
				cif.ovf = cif.amt > 0;
			end
			sbfu_pkg::OP_CIRC: begin
				cif.res = rot_w[2*sbfu_pkg::FIX_W-1 -: sbfu_pkg::FIX_W];
				cif.zero = cif.res == '0;
			end
			sbfu_pkg::OP_BIT_ZERO: begin
				cif.res = cif.src & ~bmask;
				cif.zero = cif.res == '0;
				cif.ovf = big;
			end
			sbfu_pkg::OP_BIT_ONE: begin
				cif.res = cif.src | bmask;
				cif.zero = cif.res == '0;
				cif.ovf = big;
			end
			sbfu_pkg::OP_BIT_FLIP: begin
				cif.res = cif.src ^ bmask;
				cif.zero = cif.res == '0;
				cif.ovf = big;
			end
			sbfu_pkg::OP_BIT_TEST: begin
				cif.we = 1'b0;
				cif.zero = (cif.src & bmask) == '0;
				cif.ovf = big;
			end
			sbfu_pkg::OP_DEPOSIT: begin
				cif.res = dep_w[sbfu_pkg::FIX_W-1:0];
				cif.zero = cif.res == '0;
				cif.ovf = span > sbfu_pkg::SPAN_MAX;
			end
			sbfu_pkg::OP_DEPOSIT_OR: begin
				cif.res = cif.dst | dep_w[sbfu_pkg::FIX_W-1:0];
				cif.zero = cif.res == '0;
				cif.ovf = span > sbfu_pkg::SPAN_MAX;
			end
			sbfu_pkg::OP_NONE: begin
				cif.we = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// File: hdl/sbfu_top.sv
// shifter bit-field unit: bus slave, operand registers and result capture
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sbfu_top (
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic [sbfu_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
	input wire logic [sbfu_pkg::BE_W-1:0] AVS_BYTEENABLE_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [sbfu_pkg::BUS_W-1:0] AVS_WRITEDATA_I,
	output logic [sbfu_pkg::BUS_W-1:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	output logic [sbfu_pkg::WORD_W-1:0] RESULT_WORD_O,
	output logic RESULT_WE_O,
	output logic SHIFTER_ZERO_FLAG_O,
	output logic SHIFTER_OVERFLOW_FLAG_O,
	output logic SHIFTER_SIGN_FLAG_O,
	output logic DONE_O
);

	// ****************************************
	// reset release
	// ****************************************
	logic [1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_sync_reg <= '0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	// ****************************************
	// bus handshake
	// ****************************************
	// every access takes exactly one wait cycle; reads get a registered
	// answer, which costs a cycle but keeps the mux off the output path
	logic req;
	logic ack_reg;
	logic wr_done;
	logic rd_load;

	assign req = AVS_READ_I | AVS_WRITE_I;
	assign AVS_WAITREQUEST_O = req & ~ack_reg;
	assign wr_done = AVS_WRITE_I & ack_reg;
	assign rd_load = AVS_READ_I & ~ack_reg;

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	function automatic logic [sbfu_pkg::BUS_W-1:0] be_merge(
		input logic [sbfu_pkg::BUS_W-1:0] old_val,
		input logic [sbfu_pkg::BUS_W-1:0] new_val,
		input logic [sbfu_pkg::BE_W-1:0] be
	);
		logic [sbfu_pkg::BUS_W-1:0] v;
		v = old_val;
		for (int i = 0; i < sbfu_pkg::BE_W; i++) begin
			if (be[i]) begin
				v[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return v;
	endfunction

	function automatic logic wr_hit(input logic [sbfu_pkg::ADDR_W-1:0] off);
		return wr_done && (AVS_ADDRESS_I == off);
	endfunction

	// ****************************************
	// operand registers
	// ****************************************
	logic [sbfu_pkg::FIX_W-1:0] src_reg;
	logic [sbfu_pkg::FIX_W-1:0] dst_reg;
	logic [sbfu_pkg::FIX_W-1:0] ctrl_reg;
	logic [sbfu_pkg::BUS_W-1:0] cmd_reg;
	logic go_reg;

	sbfu_if cif ();

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			src_reg <= '0;
			ctrl_reg <= '0;
		end else begin
			if (wr_hit(sbfu_pkg::REG_SRC)) begin
				src_reg <= be_merge(src_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
			if (wr_hit(sbfu_pkg::REG_CTRL)) begin
				ctrl_reg <= be_merge(ctrl_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
		end
	end

	// the destination doubles as the write-back target, so a result wins;
	// a bus write cannot land in the same cycle as an operation finishes
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			dst_reg <= '0;
		end else if (go_reg && cif.we) begin
			dst_reg <= cif.res;
		end else if (wr_hit(sbfu_pkg::REG_DST)) begin
			dst_reg <= be_merge(dst_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg <= '0;
			go_reg <= 1'b0;
		end else begin
			go_reg <= wr_hit(sbfu_pkg::REG_CMD);
			if (wr_hit(sbfu_pkg::REG_CMD)) begin
				cmd_reg <= be_merge(cmd_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
		end
	end

	// ****************************************
	// operand selection
	// ****************************************
	logic use_imm;
	logic [sbfu_pkg::IMM_W-1:0] imm;

	assign imm = cmd_reg[sbfu_pkg::CMD_IMM_LSB +: sbfu_pkg::IMM_W];
	assign use_imm = cmd_reg[sbfu_pkg::CMD_IMM_SEL];
	assign cif.kind =
		sbfu_pkg::decode_op(cmd_reg[sbfu_pkg::CMD_OPC_LSB +: sbfu_pkg::OPC_W]);
	assign cif.src = src_reg;
	assign cif.dst = dst_reg;
	assign cif.amt = use_imm ?
		{{(sbfu_pkg::FIX_W-sbfu_pkg::SHIMM_W){imm[sbfu_pkg::SHIMM_W-1]}},
		imm[sbfu_pkg::SHIMM_W-1:0]} : ctrl_reg;
	assign cif.fld_len = use_imm ? imm[sbfu_pkg::LEN_LSB +: sbfu_pkg::FLD_W] :
		ctrl_reg[sbfu_pkg::LEN_LSB +: sbfu_pkg::FLD_W];
	assign cif.fld_pos = use_imm ? imm[sbfu_pkg::POS_LSB +: sbfu_pkg::FLD_W] :
		ctrl_reg[sbfu_pkg::POS_LSB +: sbfu_pkg::FLD_W];

	sbfu_core u_core (
		.cif(cif)
	);

	// ****************************************
	// result and flag capture
	// ****************************************
	logic [sbfu_pkg::WORD_W-1:0] res_word_reg;
	logic [sbfu_pkg::FIX_W-1:0] res_fix;
	logic we_reg;
	logic done_pulse_reg;
	logic zero_reg;
	logic ovf_reg;
	logic sign_reg;
	logic done_reg;
	logic bad_reg;

	assign res_fix = res_word_reg[sbfu_pkg::WORD_W-1 -: sbfu_pkg::FIX_W];

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			zero_reg <= 1'b0;
			ovf_reg <= 1'b0;
			sign_reg <= 1'b0;
			bad_reg <= 1'b0;
		end else if (go_reg) begin
			zero_reg <= cif.zero;
			ovf_reg <= cif.ovf;
			sign_reg <= cif.sign;
			bad_reg <= cif.kind == sbfu_pkg::OP_NONE;
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			res_word_reg <= '0;
		end else if (go_reg && cif.we) begin
			res_word_reg <= {cif.res, {sbfu_pkg::EXT_W{1'b0}}};
		end
	end

	// done is cleared by the next command write and set when it finishes;
	// the two never meet in one cycle, as completion trails the write
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			we_reg <= 1'b0;
			done_pulse_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			we_reg <= go_reg & cif.we;
			done_pulse_reg <= go_reg;
			if (go_reg) begin
				done_reg <= 1'b1;
			end else if (wr_hit(sbfu_pkg::REG_CMD)) begin
				done_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// read data
	// ****************************************
	logic [sbfu_pkg::BUS_W-1:0] status_word;
	logic [sbfu_pkg::BUS_W-1:0] rdata_reg;

	always_comb begin
		status_word = '0;
		status_word[sbfu_pkg::ST_ZERO] = zero_reg;
		status_word[sbfu_pkg::ST_OVF] = ovf_reg;
		status_word[sbfu_pkg::ST_SIGN] = sign_reg;
		status_word[sbfu_pkg::ST_DONE] = done_reg;
		status_word[sbfu_pkg::ST_BAD] = bad_reg;
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else if (rd_load) begin
			case (AVS_ADDRESS_I)
				sbfu_pkg::REG_SRC: rdata_reg <= src_reg;
				sbfu_pkg::REG_DST: rdata_reg <= dst_reg;
				sbfu_pkg::REG_CTRL: rdata_reg <= ctrl_reg;
				sbfu_pkg::REG_CMD: rdata_reg <= cmd_reg;
				sbfu_pkg::REG_STAT: rdata_reg <= status_word;
				default: rdata_reg <= '0;
			endcase
		end
	end

	assign AVS_READDATA_O = rdata_reg;
	assign RESULT_WORD_O = res_word_reg;
	assign RESULT_WE_O = we_reg;
	assign SHIFTER_ZERO_FLAG_O = zero_reg;
	assign SHIFTER_OVERFLOW_FLAG_O = ovf_reg;
	assign SHIFTER_SIGN_FLAG_O = sign_reg;
	assign DONE_O = done_pulse_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!rst_n);

	sequence s_cmd_write;
		wr_done && (AVS_ADDRESS_I == sbfu_pkg::REG_CMD);
	endsequence

	sequence s_finish;
		go_reg ##1 (done_pulse_reg && done_reg);
	endsequence

	a_single_cycle_done: assert property (
		s_cmd_write |=> s_finish)
		else $error("operation did not finish one cycle after launch");

	a_ash_flags: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_ASH_OR |=>
		ovf_reg == ($past(cif.amt) > 0) && !sign_reg && RESULT_WE_O)
		else $error("or-shift flags wrong");

	a_ash_keep_dst: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_ASH_OR |=>
		(res_fix & $past(dst_reg)) == $past(dst_reg) && dst_reg == res_fix)
		else $error("or-shift lost destination bits");

	a_ext_zero: assert property (
		RESULT_WE_O |-> RESULT_WORD_O[sbfu_pkg::EXT_W-1:0] == '0)
		else $error("extension field not zero");

	a_rot_flags: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_CIRC |=>
		!ovf_reg && !sign_reg && zero_reg == (res_fix == '0))
		else $error("rotate flags wrong");

	a_bit_range: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_BIT_ZERO && cif.amt > sbfu_pkg::BIT_MAX
		|=> ovf_reg && res_fix == $past(src_reg))
		else $error("out-of-range clear altered the operand");

	a_clear_bit: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_BIT_ZERO && cif.amt >= 0 &&
		cif.amt <= sbfu_pkg::BIT_MAX |=>
		(res_fix & (32'h1 << $past(cif.amt[sbfu_pkg::SH_W-1:0]))) == '0)
		else $error("selected bit not cleared");

	a_test_nowrite: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_BIT_TEST |=>
		!RESULT_WE_O && $stable(dst_reg) && $stable(res_word_reg))
		else $error("bit test wrote a destination");

	a_test_ovf: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_BIT_TEST && cif.amt > sbfu_pkg::BIT_MAX
		|=> zero_reg && ovf_reg && !sign_reg)
		else $error("bit test out-of-range flags wrong");

	a_dep_ovf: assert property (
		go_reg && (cif.kind == sbfu_pkg::OP_DEPOSIT ||
		cif.kind == sbfu_pkg::OP_DEPOSIT_OR) |=>
		ovf_reg == ($past(cif.fld_len) + $past(cif.fld_pos) > sbfu_pkg::SPAN_MAX))
		else $error("deposit overflow flag wrong");

	a_dep_or_keep: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_DEPOSIT_OR |=>
		(res_fix & $past(dst_reg)) == $past(dst_reg))
		else $error("or-deposit lost destination bits");

	a_set_bit: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_BIT_ONE && cif.amt >= 0 &&
		cif.amt <= sbfu_pkg::BIT_MAX |=>
		(res_fix & (32'h1 << $past(cif.amt[sbfu_pkg::SH_W-1:0]))) != '0)
		else $error("selected bit not set");

	a_flip_bit: assert property (
		go_reg && cif.kind == sbfu_pkg::OP_BIT_FLIP && cif.amt >= 0 &&
		cif.amt <= sbfu_pkg::BIT_MAX |=>
		(res_fix ^ $past(src_reg)) == (32'h1 << $past(cif.amt[sbfu_pkg::SH_W-1:0])))
		else $error("toggle changed other than one bit");

	a_dep_zero: assert property (
		go_reg && (cif.kind == sbfu_pkg::OP_DEPOSIT ||
		cif.kind == sbfu_pkg::OP_DEPOSIT_OR) |=> zero_reg == (res_fix == '0) && !sign_reg)
		else $error("deposit zero or sign flag wrong");

endmodule
`default_nettype wire

// File: dv/sbfu_rf_model.sv
// register-file stand-in that keeps the last result word the unit writes back and counts the write-backs
`timescale 1ns/1ps
`default_nettype none
module sbfu_rf_model (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [sbfu_pkg::WORD_W-1:0] word_i,
	input wire logic we_i,
	output logic [sbfu_pkg::WORD_W-1:0] word_o,
	output logic [7:0] count_o
);
	logic [sbfu_pkg::WORD_W-1:0] word_reg;
	logic [7:0] count_reg;
	// ********************
	// write-back port
	// ********************
	// only a strobed word lands, so a pulse longer than one cycle shows up as extra counts
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			word_reg <= 40'h0;
			count_reg <= 8'h0;
		end else if (we_i) begin
			word_reg <= word_i;
			count_reg <= count_reg + 8'h1;
		end
	end
	assign word_o = word_reg;
	assign count_o = count_reg;
endmodule
`default_nettype wire

// File: dv/tb_shifter_bit_field_unit.sv
// self-checking bench for the shifter bit-field unit, driven over its register bus
`timescale 1ns/1ps
`default_nettype none
module tb_shifter_bit_field_unit;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [3:0] be = 4'hf;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic waitreq, we, zf, vf, sf, done;
	logic [39:0] word, m_word;
	logic [7:0] m_count;
	logic [7:0] bops [4] = '{8'hc4, 8'hc0, 8'hc8, 8'hcc};
	logic [31:0] bpos [5] = '{32'h0, 32'h1f, 32'h20, 32'hffffffff, 32'h3};
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;

	sbfu_top i_dut (.CLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(addr),
		.AVS_BYTEENABLE_I(be), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .RESULT_WORD_O(word),
		.RESULT_WE_O(we), .SHIFTER_ZERO_FLAG_O(zf), .SHIFTER_OVERFLOW_FLAG_O(vf),
		.SHIFTER_SIGN_FLAG_O(sf), .DONE_O(done));
	sbfu_rf_model i_rf (.clk_i(clk), .arst_n_i(arst_n), .word_i(word), .we_i(we),
		.word_o(m_word), .count_o(m_count));

	always #12.5 clk = ~clk;

	// ********************
	// checking and bus tasks
	// ********************
	task automatic chk(input logic [39:0] g, input logic [39:0] x, input string w);
		n_compared++;
		if (g !== x) begin
			fails++;
			$display("Error at %0t: %s got %h expected %h", $time, w, g, x);
		end
	endtask

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fails++;
			close_out();
		end
	end

	task automatic bus(input logic w, input logic [4:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		be <= b;
		wdata <= d;
		wr <= w;
		rd <= !w;
		// the request stands untouched until a rising edge samples waitrequest low
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		r = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20) chk(40'h1, 40'h0, "bus wait");
	endtask

	// returns {write, overflow, zero, result}
	function automatic logic [34:0] ref_op(input logic [7:0] o, input logic [31:0] s, d,
		input logic signed [31:0] a, input logic [5:0] ln, ps);
		logic [31:0] r, sh, m;
		logic [63:0] t;
		logic z, v, w;
		r = d;
		z = 1'b0;
		v = 1'b0;
		w = 1'b1;
		m = (a >= 0 && a <= 31) ? 32'h1 << a : 32'h0;
		if (a >= 32) sh = 32'h0;
		else if (a >= 0) sh = s << a;
		else if (a > -32) sh = $signed(s) >>> (-a);
		else sh = {32{s[31]}};
		t = (ln >= 32) ? 64'hffffffff : (64'h1 << ln) - 64'h1;
		t = (t & {32'h0, s}) << ps;
		case (o)
		sbfu_pkg::OPC_ASH_OR: begin
			r = sh | d;
			v = (a > 0);
		end
		sbfu_pkg::OPC_CIRC: r = (s << a[4:0]) | (s >> (32 - a[4:0]));
		sbfu_pkg::OPC_BIT_ZERO: r = s & ~m;
		sbfu_pkg::OPC_BIT_ONE: r = s | m;
		sbfu_pkg::OPC_BIT_FLIP: r = s ^ m;
		sbfu_pkg::OPC_BIT_TEST: begin
			w = 1'b0;
			z = ((s & m) == 32'h0);
		end
		sbfu_pkg::OPC_DEPOSIT: r = t[31:0];
		sbfu_pkg::OPC_DEPOSIT_OR: r = t[31:0] | d;
		default: w = 1'b0;
		endcase
		if (o[7:6] == 2'b11) v = (a > 31);
		if (o == sbfu_pkg::OPC_DEPOSIT || o == sbfu_pkg::OPC_DEPOSIT_OR) v = (int'(ln) + int'(ps) > 32);
		if (w) z = (o == sbfu_pkg::OPC_ASH_OR) ? (sh == 32'h0) : (r == 32'h0);
		return {w, v, z, r};
	endfunction

	task automatic run(input logic [7:0] opc, input logic imm, input logic [11:0] iv,
		input logic [31:0] s, d, c);
		logic [34:0] e;
		logic [7:0] c0;
		int n;
		e = ref_op(opc, s, d, imm ? {{24{iv[7]}}, iv[7:0]} : c, imm ? iv[5:0] : c[5:0],
			imm ? iv[11:6] : c[11:6]);
		bus(1'b1, sbfu_pkg::REG_SRC, 4'hf, s, q);
		bus(1'b1, sbfu_pkg::REG_DST, 4'hf, d, q);
		bus(1'b1, sbfu_pkg::REG_CTRL, 4'hf, c, q);
		c0 = m_count;
		bus(1'b1, sbfu_pkg::REG_CMD, 4'hf, {4'h0, iv, 7'h0, imm, opc}, q);
		n = 0;
		while (done !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		chk({39'h0, done}, 40'h1, "done pulse");
		chk({37'h0, sf, vf, zf}, {37'h0, 1'b0, e[33], e[32]}, "flags");
		chk({39'h0, we}, {39'h0, e[34]}, "write strobe");
		if (e[34]) chk(word, {e[31:0], 8'h00}, "result word");
		bus(1'b0, sbfu_pkg::REG_DST, 4'hf, 32'h0, q);
		chk({8'h0, q}, {8'h0, e[31:0]}, "dst readback");
		chk({32'h0, m_count - c0}, {39'h0, e[34]}, "write-backs");
		if (e[34]) chk(m_word, {e[31:0], 8'h00}, "stored word");
		$display("test opcode %h done", opc);
	endtask

	// ********************
	// test sequence
	// ********************
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk({word[39:35], zf, vf, sf, done, we}, 40'h0, "reset outputs");
		chk(word, 40'h0, "reset word");
		// byte lanes and unmapped places
		bus(1'b1, sbfu_pkg::REG_CTRL, 4'hf, 32'h11223344, q);
		bus(1'b1, sbfu_pkg::REG_CTRL, 4'h3, 32'haabbccdd, q);
		bus(1'b0, sbfu_pkg::REG_CTRL, 4'hf, 32'h0, q);
		chk({8'h0, q}, {8'h0, 32'h1122ccdd}, "byte enables");
		bus(1'b1, 5'h14, 4'hf, 32'hffffffff, q);
		bus(1'b0, 5'h14, 4'hf, 32'h0, q);
		chk({8'h0, q}, 40'h0, "unmapped read");
		$display("test bus done");
		run(sbfu_pkg::OPC_ASH_OR, 1'b0, 12'h000, 32'h000000f1, 32'h1, 32'h4);
		run(sbfu_pkg::OPC_ASH_OR, 1'b1, 12'h0fc, 32'h80000010, 32'h100, 32'h0);
		run(sbfu_pkg::OPC_ASH_OR, 1'b1, 12'h07f, 32'h12345678, 32'hf00000, 32'h0);
		run(sbfu_pkg::OPC_ASH_OR, 1'b1, 12'h080, 32'h80000000, 32'h0, 32'h0);
		run(sbfu_pkg::OPC_ASH_OR, 1'b0, 12'h000, 32'h0, 32'h5, 32'h0);
		run(sbfu_pkg::OPC_CIRC, 1'b0, 12'h000, 32'h80000001, 32'hffffffff, 32'h3);
		run(sbfu_pkg::OPC_CIRC, 1'b1, 12'h0ff, 32'h80000001, 32'h0, 32'h0);
		run(sbfu_pkg::OPC_CIRC, 1'b1, 12'h0e0, 32'h0, 32'h1, 32'h0);
		foreach (bops[i]) begin
			foreach (bpos[j]) begin
				run(bops[i], 1'b0, 12'h000, 32'h5a5a00ff, 32'h9, bpos[j]);
			end
			run(bops[i], 1'b1, 12'h01f, 32'h80000000, 32'h0, 32'h0);
		end
		run(sbfu_pkg::OPC_DEPOSIT, 1'b1, 12'h34e, 32'hffffabcd, 32'hffffffff, 32'h0);
		run(sbfu_pkg::OPC_DEPOSIT, 1'b0, 12'h000, 32'h89abcdef, 32'h1, 32'h20);
		run(sbfu_pkg::OPC_DEPOSIT, 1'b0, 12'h000, 32'h000fffff, 32'h0, 32'h514);
		run(sbfu_pkg::OPC_DEPOSIT, 1'b1, 12'hfff, 32'hffffffff, 32'h7, 32'h0);
		run(sbfu_pkg::OPC_DEPOSIT_OR, 1'b1, 12'h108, 32'ha5, 32'hf000000f, 32'h0);
		run(sbfu_pkg::OPC_DEPOSIT_OR, 1'b1, 12'h7c2, 32'h3, 32'h1, 32'h0);
		run(sbfu_pkg::OPC_DEPOSIT_OR, 1'b0, 12'h000, 32'h1, 32'h0, 32'h7c1);
		// an unknown opcode must leave the destination alone and clear the flags
		run(8'h00, 1'b0, 12'h000, 32'h1, 32'h2, 32'h0);
		bus(1'b0, sbfu_pkg::REG_STAT, 4'hf, 32'h0, q);
		chk({39'h0, q[sbfu_pkg::ST_BAD]}, 40'h1, "illegal status");
		close_out();
	end
endmodule
`default_nettype wire
